/* pkg/rtseq_pkg.sv */
// Package of constants and types for the reset time-out sequencer
package rtseq_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS   = 4;
	localparam int DELAY_TIME_MS   = 96;
	localparam int DELAY_CYCLES    = (DELAY_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STARTUP_PERIODS = 1024;
	localparam int DELAY_W         = 25;
	localparam int STARTUP_W       = 11;

	// ==========================================================
	// Flag reset values
	localparam logic FLAG_SET     = 1'b1;
	localparam logic FLAG_CLR     = 1'b0;

	// ==========================================================
	// Oscillator configuration
	typedef enum logic [1:0] {
		OSC_LOW_FREQ_CRYSTAL = 2'h0,
		OSC_CRYSTAL          = 2'h1,
		OSC_EXTERNAL_CLOCK   = 2'h2,
		OSC_RESISTOR_CAP     = 2'h3
	} rtseq_osc_mode_t;

	// ==========================================================
	// Sequencer states, one-hot
	typedef enum logic [4:0] {
		S_POR   = 5'h01,
		S_HOLD  = 5'h02,
		S_TIME  = 5'h04,
		S_RUN   = 5'h08,
		S_SLEEP = 5'h10
	} rtseq_state_t;

	// Kind of time-out owed to the pending event
	typedef enum logic [1:0] {
		K_NONE  = 2'h0,
		K_POWER = 2'h1,
		K_WAKE  = 2'h2
	} rtseq_kind_t;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic sleepEnter;
		logic wakeEvent;
		logic watchdogTimeout;
		logic watchdogClear;
	} rtseq_core_ev_t;

	typedef struct packed {
		logic deviceReset;
		logic watchdogExpiredFlag;
		logic sleepEnteredFlag;
		logic oscCounterBusy;
		logic delayTimerBusy;
	} rtseq_status_t;

endpackage

/* hdl/rtseq_top.sv */
// Reset time-out sequencer: start-up counter, power-up delay and reset-cause flags
// ==========================================================
// Overview of operation
// - Start-up counter holds device 1024 oscillator periods after power-on or wake.
// - Start-up delay on power-on in all modes; on wake-up from sleep only in crystal modes.
// - Counter advances on oscillator pin pulses once amplitude crosses input thresholds.
// - After power-on trip with master clear high, both timers start together.
// - Power-up greater of 96 ms/1024 periods; wake 1024 in crystal; clear none.
// - Time-out sequence begins once master clear pin is high; a low pin restarts it.
// - Power-on, master clear in run, or watchdog clear set both flags to one.
// - Master clear in sleep or interrupt wake sets expired flag, clears sleep flag.
// - Watchdog reset clears expired flag; sleep flag one in run, zero in sleep.
module rtseq_top
	import rtseq_pkg::*;
#(
	parameter int STARTUP_COUNT = STARTUP_PERIODS,
	parameter int DELAY_COUNT   = DELAY_CYCLES
) (
	// Clock and reset
	input  wire logic            clk,
	input  wire logic            reset,
	input  wire logic            clkEn,
	// Asynchronous pins and analog indications
	input  wire logic            porTrip,
	input  wire logic            masterClearPin,
	input  wire logic            oscillatorInputPin,
	input  wire logic            oscAmplitudeOk,
	// Configuration
	input  wire rtseq_osc_mode_t oscMode,
	// Core events, one-cycle pulses
	input  wire rtseq_core_ev_t  coreEv,
	// Status
	output rtseq_status_t        status
);

	// ==========================================================
	// Pin synchronisers
	logic [3:0] syncA_r, syncA_nxt;
	logic [3:0] syncB_r, syncB_nxt;
	logic       oscPrev_r, oscPrev_nxt;
	logic       porOk, clearHigh, oscLevel, oscAmp, oscEdge;

	always_comb begin
		syncA_nxt   = {porTrip, masterClearPin, oscillatorInputPin, oscAmplitudeOk};
		syncB_nxt   = syncA_r;
		oscPrev_nxt = syncB_r[1];
	end

	assign porOk     = syncB_r[3];
	assign clearHigh = syncB_r[2];
	assign oscLevel  = syncB_r[1];
	assign oscAmp    = syncB_r[0];
	assign oscEdge   = oscLevel & ~oscPrev_r;

	always_ff @(posedge clk) begin
		if (reset) begin
			syncA_r   <= 4'h0;
			syncB_r   <= 4'h0;
			oscPrev_r <= 1'b0;
		end else if (clkEn) begin
			syncA_r   <= syncA_nxt;
			syncB_r   <= syncB_nxt;
			oscPrev_r <= oscPrev_nxt;
		end
	end

	// ==========================================================
	// Sequencer and flags
	rtseq_state_t state_r, state_nxt;
	rtseq_kind_t  kind_r, kind_nxt;
	logic         expired_r, expired_nxt;
	logic         slept_r, slept_nxt;
	logic         rstOut_r, rstOut_nxt;
	logic [STARTUP_W-1:0] startCnt_r, startCnt_nxt;
	logic [DELAY_W-1:0]   delayCnt_r, delayCnt_nxt;
	logic         crystal, needStart, needDelay, startDone, delayDone, allDone;

	assign crystal   = (oscMode == OSC_CRYSTAL) || (oscMode == OSC_LOW_FREQ_CRYSTAL);
	// Power-up always owes both; wake owes the counter only with a crystal
	assign needStart = (kind_r == K_POWER) || ((kind_r == K_WAKE) && crystal);
	assign needDelay = (kind_r == K_POWER);
	assign startDone = (startCnt_r == STARTUP_W'(STARTUP_COUNT));
	assign delayDone = (delayCnt_r == DELAY_W'(DELAY_COUNT));
	assign allDone   = (!needStart || startDone) && (!needDelay || delayDone);

	always_comb begin
		state_nxt   = state_r;
		kind_nxt    = kind_r;
		expired_nxt = expired_r;
		slept_nxt   = slept_r;
		startCnt_nxt = startCnt_r;
		delayCnt_nxt = delayCnt_r;
		if (!porOk) begin
			state_nxt   = S_POR;
			kind_nxt    = K_POWER;
			expired_nxt = FLAG_SET;
			slept_nxt   = FLAG_SET;
		end else begin
			unique case (state_r)
				S_POR: begin
					// Trip point reached: start at once if master clear already high
					state_nxt = clearHigh ? S_TIME : S_HOLD;
				end
				S_HOLD: begin
					if (clearHigh) begin
						state_nxt = S_TIME;
					end
				end
				S_TIME: begin
					if (!clearHigh) begin
						state_nxt = S_HOLD;
					end else if (allDone) begin
						state_nxt = S_RUN;
					end
				end
				S_RUN: begin
					if (!clearHigh) begin
						state_nxt   = S_HOLD;
						kind_nxt    = K_NONE;
						expired_nxt = FLAG_SET;
						slept_nxt   = FLAG_SET;
					end else if (coreEv.watchdogTimeout) begin
						state_nxt   = S_TIME;
						kind_nxt    = K_NONE;
						expired_nxt = FLAG_CLR;
						slept_nxt   = FLAG_SET;
					end else if (coreEv.sleepEnter) begin
						state_nxt = S_SLEEP;
					end else if (coreEv.watchdogClear) begin
						expired_nxt = FLAG_SET;
						slept_nxt   = FLAG_SET;
					end
				end
				S_SLEEP: begin
					if (!clearHigh) begin
						state_nxt   = S_HOLD;
						kind_nxt    = K_WAKE;
						expired_nxt = FLAG_SET;
						slept_nxt   = FLAG_CLR;
					end else if (coreEv.watchdogTimeout) begin
						state_nxt   = S_TIME;
						kind_nxt    = K_WAKE;
						expired_nxt = FLAG_CLR;
						slept_nxt   = FLAG_CLR;
					end else if (coreEv.wakeEvent) begin
						state_nxt   = S_TIME;
						kind_nxt    = K_WAKE;
						expired_nxt = FLAG_SET;
						slept_nxt   = FLAG_CLR;
					end
				end
			endcase
		end
		// Timers restart whenever the sequence is not running
		if (state_nxt != S_TIME || state_r != S_TIME) begin
			startCnt_nxt = '0;
			delayCnt_nxt = '0;
		end else begin
			if (needStart && !startDone && oscAmp && oscEdge) begin
				startCnt_nxt = startCnt_r + STARTUP_W'(1);
			end
			if (needDelay && !delayDone) begin
				delayCnt_nxt = delayCnt_r + DELAY_W'(1);
			end
		end
		rstOut_nxt = !((state_nxt == S_RUN) || (state_nxt == S_SLEEP));
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_r   <= S_POR;
			kind_r    <= K_POWER;
			expired_r <= FLAG_SET;
			slept_r   <= FLAG_SET;
			rstOut_r  <= 1'b1;
			startCnt_r <= '0;
			delayCnt_r <= '0;
		end else if (clkEn) begin
			state_r   <= state_nxt;
			kind_r    <= kind_nxt;
			expired_r <= expired_nxt;
			slept_r   <= slept_nxt;
			rstOut_r  <= rstOut_nxt;
			startCnt_r <= startCnt_nxt;
			delayCnt_r <= delayCnt_nxt;
		end
	end

	always_comb begin
		status.deviceReset         = rstOut_r;
		status.watchdogExpiredFlag = expired_r;
		status.sleepEnteredFlag    = slept_r;
		status.oscCounterBusy      = (state_r == S_TIME) && needStart && !startDone;
		status.delayTimerBusy      = (state_r == S_TIME) && needDelay && !delayDone;
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk iff clkEn);
	endclocking
	default disable iff (reset);

	a_start_counts_edges: assert property (
		(startCnt_r != $past(startCnt_r)) && (startCnt_r != '0) |-> $past(oscAmp && oscEdge))
		else $error("start-up counter moved without a qualified oscillator edge");

	a_release_needs_count: assert property (
		(state_r == S_TIME) && (state_nxt == S_RUN) && needStart
			|-> startCnt_r == STARTUP_W'(STARTUP_COUNT))
		else $error("released before start-up count complete");

	a_no_count_clock_wake: assert property (
		(state_r == S_TIME) && (kind_r == K_WAKE) && !crystal |=> state_r != S_TIME)
		else $error("start-up delay applied on wake in non-crystal mode");

	a_power_both_run: assert property (
		(state_r == S_TIME) && (kind_r == K_POWER) && !startDone && !delayDone
			|=> (delayCnt_r == $past(delayCnt_r) + DELAY_W'(1)) || (state_r != S_TIME))
		else $error("power-up delay timer not running with counter");

	a_clear_no_timeout: assert property (
		(state_r == S_TIME) && (kind_r == K_NONE) && clearHigh && porOk |=> state_r == S_RUN)
		else $error("master clear reset imposed a time-out");

	a_hold_until_edge: assert property (
		(state_r == S_HOLD) && !clearHigh && porOk |=> state_r == S_HOLD)
		else $error("sequence started before master clear rose");

	a_clear_sets_flags: assert property (
		(state_r == S_RUN) && porOk && clearHigh && coreEv.watchdogClear
			&& !coreEv.watchdogTimeout && !coreEv.sleepEnter
			|=> expired_r && slept_r)
		else $error("watchdog clear did not set both flags");

	a_wake_flags: assert property (
		(state_r == S_SLEEP) && porOk && clearHigh && coreEv.wakeEvent && !coreEv.watchdogTimeout
			|=> !slept_r && expired_r)
		else $error("interrupt wake flags wrong");

	a_watchdog_sleep_flags: assert property (
		(state_r == S_SLEEP) && porOk && clearHigh && coreEv.watchdogTimeout
			|=> !expired_r && !slept_r)
		else $error("watchdog reset in sleep flags wrong");

	a_reset_held: assert property (
		(state_r == S_TIME) && !allDone |=> status.deviceReset)
		else $error("internal reset dropped with a timer still running");

	c_power_up: cover property ((state_r == S_TIME) && (kind_r == K_POWER) ##1 state_r == S_RUN);
	c_wake_crystal: cover property ((kind_r == K_WAKE) && crystal && (state_r == S_TIME)
		##1 state_r == S_RUN);
	c_watchdog_run: cover property ((state_r == S_RUN) && coreEv.watchdogTimeout);

endmodule

/* test/rtseq_ext_model.sv */
// Model of the external reset circuit and the crystal source
module rtseq_ext_model (
	// Control from the bench
	input  wire logic supplyOk,
	input  wire logic clearHoldLow,
	// Pins into the device
	output logic      porTrip,
	output logic      masterClearPin,
	output logic      oscillatorInputPin,
	output logic      oscAmplitudeOk
);
	timeunit 1ns;
	timeprecision 1ps;

	int halfCnt = 0;

	initial oscillatorInputPin = 1'b0;
	assign porTrip = supplyOk;
	// Pin kept low while the supply is not yet good
	assign masterClearPin = supplyOk & ~clearHoldLow;
	// Crystal swing grows slowly: 20 half periods before it is usable
	assign oscAmplitudeOk = supplyOk && (halfCnt >= 20);

	// Oscillator period 40 ns, stopped without supply
	always #20 begin
		if (supplyOk) begin
			oscillatorInputPin = ~oscillatorInputPin;
			halfCnt = halfCnt + 1;
		end else begin
			oscillatorInputPin = 1'b0;
			halfCnt = 0;
		end
	end
endmodule

/* test/rtseq_top_tb_top.sv */
// Self-checking bench for the reset time-out sequencer
module rtseq_top_tb_top import rtseq_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================
	// Setup
	localparam int STARTN = 8;
	localparam int PWRN   = 50;
	// One oscillator period is 10 clocks; allow for synchroniser slack
	localparam int LONG   = STARTN * 10 - 10;
	localparam int PWRUP  = 170;

	typedef struct {
		int              ev;
		rtseq_osc_mode_t m;
		logic            expired;
		logic            slept;
		int              cls;
	} rtseq_row_t;

	logic            clk         = 1'b0;
	logic            reset       = 1'b1;
	logic            supplyOk    = 1'b0;
	logic            clearHoldLow = 1'b0;
	logic            clkEn       = 1'b1;
	logic            porTrip;
	logic            masterClearPin;
	logic            oscillatorInputPin;
	logic            oscAmplitudeOk;
	rtseq_osc_mode_t oscMode     = OSC_CRYSTAL;
	rtseq_core_ev_t  coreEv      = '0;
	rtseq_status_t   status;
	int              fail_count  = 0;
	int              checks      = 0;
	int              n;

	// Events: 0 clear pin, 1 watchdog, 2 clear instr, 3 wake, 4 pin in sleep, 5 watchdog in sleep
	// Hold class: 0 none, 1 short, 2 start-up count
	rtseq_row_t rows[8] = '{
		'{0, OSC_CRYSTAL, 1'b1, 1'b1, 1},
		'{1, OSC_CRYSTAL, 1'b0, 1'b1, 1},
		'{2, OSC_CRYSTAL, 1'b1, 1'b1, 0},
		'{3, OSC_CRYSTAL, 1'b1, 1'b0, 2},
		'{4, OSC_LOW_FREQ_CRYSTAL, 1'b1, 1'b0, 2},
		'{5, OSC_EXTERNAL_CLOCK, 1'b0, 1'b0, 1},
		'{3, OSC_RESISTOR_CAP, 1'b1, 1'b0, 1},
		'{5, OSC_CRYSTAL, 1'b0, 1'b0, 2}
	};

	always #2 clk = ~clk;

	rtseq_ext_model ext (
		.supplyOk           (supplyOk),
		.clearHoldLow       (clearHoldLow),
		.porTrip            (porTrip),
		.masterClearPin     (masterClearPin),
		.oscillatorInputPin (oscillatorInputPin),
		.oscAmplitudeOk     (oscAmplitudeOk)
	);

	rtseq_top #(.STARTUP_COUNT(STARTN), .DELAY_COUNT(PWRN)) dut (
		.clk                (clk),
		.reset              (reset),
		.clkEn              (clkEn),
		.porTrip            (porTrip),
		.masterClearPin     (masterClearPin),
		.oscillatorInputPin (oscillatorInputPin),
		.oscAmplitudeOk     (oscAmplitudeOk),
		.oscMode            (oscMode),
		.coreEv             (coreEv),
		.status             (status)
	);

	// ==========================================
	// Tasks
	task automatic close_out();
		$display("Comparisons %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (exp !== got) begin
			fail_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
		end
	endtask

	task automatic ev(input rtseq_core_ev_t e);
		coreEv = e;
		tick(1);
		coreEv = '0;
	endtask

	// Counts cycles of internal reset; bounded so a stuck reset ends the run
	task automatic hold(output int c);
		c = 0;
		for (int i = 0; i < 600; i++) begin
			if (status.deviceReset === 1'b0 && i > 14) return;
			if (status.deviceReset === 1'b1) c++;
			tick(1);
		end
		chk("reset release", 0, 1);
		close_out();
	endtask

	task automatic doEvent(input int e);
		if (e >= 3) begin
			ev(4'h8);
			tick(2);
		end
		case (e)
			0, 4: begin
				clearHoldLow = 1'b1;
				tick(4);
				clearHoldLow = 1'b0;
			end
			1, 5: ev(4'h2);
			2: ev(4'h1);
			default: ev(4'h4);
		endcase
	endtask

	// ==========================================
	// Sequence
	initial begin
		tick(8);
		chk("reset flags", 2'h3, {status.watchdogExpiredFlag, status.sleepEnteredFlag});
		chk("reset busy", 2'h0, {status.oscCounterBusy, status.delayTimerBusy});
		reset = 1'b0;
		clearHoldLow = 1'b1;
		supplyOk = 1'b1;
		tick(200);
		chk("held by pin", 1, status.deviceReset);
		clearHoldLow = 1'b0;
		tick(20);
		chk("power-up busy", 2'h3, {status.oscCounterBusy, status.delayTimerBusy});
		hold(n);
		chk("power-up hold", 1, n + 20 >= LONG);
		for (int r = 0; r < 8; r++) begin
			oscMode = rows[r].m;
			doEvent(rows[r].ev);
			hold(n);
			tick(2);
			chk("expired flag", rows[r].expired, status.watchdogExpiredFlag);
			chk("sleep flag", rows[r].slept, status.sleepEnteredFlag);
			if (rows[r].cls == 0) chk("no hold", 0, n);
			else if (rows[r].cls == 1) chk("short hold", 1, n <= 12);
			else chk("start-up hold", 1, n >= LONG);
		end
		// Clock enable low freezes the sequencer, so a watchdog pulse is lost
		clkEn = 1'b0;
		ev(4'h2);
		tick(3);
		chk("frozen reset", 0, status.deviceReset);
		chk("frozen flags", 2'h0, {status.watchdogExpiredFlag, status.sleepEnteredFlag});
		clkEn = 1'b1;
		tick(2);
		chk("thawed flags", 2'h0, {status.watchdogExpiredFlag, status.sleepEnteredFlag});
		// Supply loss long enough to stop the crystal, then slow start in a clock mode
		supplyOk = 1'b0;
		tick(8);
		chk("loss flags", 2'h3, {status.watchdogExpiredFlag, status.sleepEnteredFlag});
		chk("loss reset", 1, status.deviceReset);
		oscMode = OSC_EXTERNAL_CLOCK;
		supplyOk = 1'b1;
		tick(60);
		chk("amplitude busy", 2'h2, {status.oscCounterBusy, status.delayTimerBusy});
		hold(n);
		chk("amplitude hold", 1, n + 60 >= PWRUP);
		close_out();
	end
endmodule
